// file: common/lsd_consts.svh
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_WORD 8'h04
`define OFS_STATUS 8'h08

// ----------------------------------------------------------------------
// Link-settings word fields
// ----------------------------------------------------------------------
`define BIT_MOD_LO 22
`define BIT_MOD_HI 23
`define BIT_FEC_BASER 24
`define BIT_FEC_RS 25
`define BIT_FEC_RSV_LO 26
`define BIT_FEC_RSV_HI 27
`define BIT_EEE 28
`define BIT_LT 29
`define BIT_PD 30

// Modulation codes
`define MOD_DEFAULT 2'h0
`define MOD_NRZ 2'h1
`define MOD_PAM4 2'h2
`define MOD_BOTH 2'h3

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_REV_LO 0
`define CTRL_REV_HI 1
`define CTRL_MOD_EN 4
`define CTRL_FEC_EN 5

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_SET_LO 0
`define STAT_SET_HI 8
`define STAT_RSVD 12
`define STAT_CNT_LO 16
`define STAT_CNT_HI 23

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_REV_RST 2'h2
`define CTRL_MOD_EN_RST 1'h1
`define CTRL_FEC_EN_RST 1'h1
`define WORD_RST 32'h0000_0000

`endif

// file: common/lsd_pkg.sv
package lsd_pkg;

    typedef enum logic [1:0] {
        REV_1_0 = 2'h0,
        REV_1_1 = 2'h1,
        REV_1_2 = 2'h2
    } rev_t;

    typedef struct packed {
        rev_t rev;
        logic mod_en;
        logic fec_en;
    } ctrl_t;

    typedef struct packed {
        logic pd;
        logic lt;
        logic eee;
        logic fec_none;
        logic fec_rs;
        logic fec_baser;
        logic mod_default;
        logic mod_pam4;
        logic mod_nrz;
    } settings_t;

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_ofs;
        logic wr_hit;
        ctrl_t ctrl;
        logic [31:0] word;
        settings_t set;
        logic update;
        logic rsvd_seen;
        logic [7:0] apply_cnt;
        logic [31:0] rdata;
    } state_t;

endpackage : lsd_pkg

// file: common/decode_if.sv
`timescale 1ns/1ps

interface decode_if;
    import lsd_pkg::*;

    logic [31:0] word;
    rev_t rev;
    logic mod_en;
    logic fec_en;
    settings_t set;
    logic rsvd_hit;

    modport host (output word, output rev, output mod_en, output fec_en,
                  input set, input rsvd_hit);
    modport dec (input word, input rev, input mod_en, input fec_en,
                 output set, output rsvd_hit);
endinterface : decode_if

// file: src/settings_word_decoder.sv
`timescale 1ns/1ps
`include "lsd_consts.svh"

module settings_word_decoder (
    decode_if.dec port // Word in, decoded settings out
);
    import lsd_pkg::*;

    logic opt_mod;
    logic opt_fec;
    logic [1:0] mod;

    always_comb begin
        // Optional fields only live at the newest revision
        opt_mod = (port.rev == REV_1_2) && port.mod_en;
        opt_fec = (port.rev == REV_1_2) && port.fec_en;
        mod = opt_mod ? port.word[`BIT_MOD_HI:`BIT_MOD_LO] : `MOD_DEFAULT;
        port.set.mod_default = (mod == `MOD_DEFAULT);
        port.set.mod_nrz = (mod == `MOD_NRZ) || (mod == `MOD_BOTH);
        port.set.mod_pam4 = (mod == `MOD_PAM4) || (mod == `MOD_BOTH);
        port.set.fec_baser = opt_fec && port.word[`BIT_FEC_BASER];
        port.set.fec_rs = opt_fec && port.word[`BIT_FEC_RS];
        // Bits 26 and 27 select nothing
        port.set.fec_none = !port.set.fec_baser && !port.set.fec_rs;
        port.set.eee = port.word[`BIT_EEE];
        port.set.lt = port.word[`BIT_LT];
        port.set.pd = port.word[`BIT_PD];
        port.rsvd_hit = |port.word[`BIT_FEC_RSV_HI:`BIT_FEC_RSV_LO];
    end

endmodule : settings_word_decoder

// file: src/link_settings_field_decoder.sv
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "lsd_consts.svh"

module link_settings_field_decoder (
    input wire logic MCLK, // 50 MHz clock
    input wire logic RST, // Synchronous reset, high
    input wire logic CE, // Clock enable, freezes state when low
    input wire logic HSEL, // AHB slave select
    input wire logic [31:0] HADDR, // AHB address
    input wire logic [1:0] HTRANS, // AHB transfer type
    input wire logic HWRITE, // AHB write
    input wire logic [2:0] HSIZE, // AHB size, word only
    input wire logic [31:0] HWDATA, // AHB write data
    input wire logic HREADY, // AHB bus ready
    output logic HREADYOUT, // AHB slave ready
    output logic HRESP, // AHB response, always OKAY
    output logic [31:0] HRDATA, // AHB read data
    input wire logic CMD_VALID, // Link-settings word from command path
    input wire logic [31:0] CMD_WORD, // Link-settings word
    output lsd_pkg::rev_t REV, // Active protocol revision
    output logic MOD_NRZ, // NRZ enabled
    output logic MOD_PAM4, // PAM-4 enabled
    output logic MOD_DEFAULT, // Default modulation
    output logic FEC_BASER, // BASE-R FEC selected
    output logic FEC_RS, // RS-FEC selected
    output logic FEC_NONE, // No FEC selected
    output logic EEE_EN, // Energy-efficient Ethernet on
    output logic LT_EN, // Link training on
    output logic PD_EN, // Parallel detect on
    output logic SETTINGS_UPDATE // Pulse: settings re-decoded
);
    import lsd_pkg::*;

    // ------------------------------------------------------------------
    // State and decoder
    // ------------------------------------------------------------------
    state_t st_reg;
    state_t st_next;

    logic bus_take;
    logic addr_hit;
    logic wr_ctrl;
    logic wr_word;
    logic wr_stat;
    logic apply;
    logic [31:0] new_word;

    decode_if dif ();

    settings_word_decoder u_dec (
        .port(dif.dec)
    );

    // ------------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_view(input logic [7:0] ofs, input state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (ofs)
            `OFS_CTRL: begin
                v[`CTRL_REV_HI:`CTRL_REV_LO] = s.ctrl.rev;
                v[`CTRL_MOD_EN] = s.ctrl.mod_en;
                v[`CTRL_FEC_EN] = s.ctrl.fec_en;
            end
            `OFS_WORD: begin
                v = s.word;
            end
            `OFS_STATUS: begin
                v[`STAT_SET_HI:`STAT_SET_LO] = s.set;
                v[`STAT_RSVD] = s.rsvd_seen;
                v[`STAT_CNT_HI:`STAT_CNT_LO] = s.apply_cnt;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction : read_view

    // ------------------------------------------------------------------
    // Reset image
    // ------------------------------------------------------------------
    function automatic state_t reset_state();
        state_t s;
        s.wr_pend = 1'b0;
        s.wr_ofs = 8'h00;
        s.wr_hit = 1'b0;
        s.ctrl.rev = rev_t'(`CTRL_REV_RST);
        s.ctrl.mod_en = `CTRL_MOD_EN_RST;
        s.ctrl.fec_en = `CTRL_FEC_EN_RST;
        s.word = `WORD_RST;
        s.set.pd = 1'b0;
        s.set.lt = 1'b0;
        s.set.eee = 1'b0;
        s.set.fec_none = 1'b1;
        s.set.fec_rs = 1'b0;
        s.set.fec_baser = 1'b0;
        s.set.mod_default = 1'b1;
        s.set.mod_pam4 = 1'b0;
        s.set.mod_nrz = 1'b0;
        s.update = 1'b0;
        s.rsvd_seen = 1'b0;
        s.apply_cnt = 8'h00;
        s.rdata = 32'h0000_0000;
        return s;
    endfunction : reset_state

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        bus_take = HSEL && HREADY && HTRANS[1];
        addr_hit = (HADDR[31:8] == 24'h00_0000) && (HADDR[1:0] == 2'h0);

        // Data phase of a write captured in the previous cycle
        wr_ctrl = st_reg.wr_pend && st_reg.wr_hit && (st_reg.wr_ofs == `OFS_CTRL);
        wr_word = st_reg.wr_pend && st_reg.wr_hit && (st_reg.wr_ofs == `OFS_WORD);
        wr_stat = st_reg.wr_pend && st_reg.wr_hit && (st_reg.wr_ofs == `OFS_STATUS);

        if (wr_ctrl) begin
            st_next.ctrl.rev = rev_t'(HWDATA[`CTRL_REV_HI:`CTRL_REV_LO]);
            st_next.ctrl.mod_en = HWDATA[`CTRL_MOD_EN];
            st_next.ctrl.fec_en = HWDATA[`CTRL_FEC_EN];
        end

        // Command path wins over a register write in the same cycle
        new_word = st_reg.word;
        apply = 1'b0;
        if (wr_word) begin
            new_word = HWDATA;
            apply = 1'b1;
        end
        if (CMD_VALID) begin
            new_word = CMD_WORD;
            apply = 1'b1;
        end
        st_next.word = new_word;

        // Decode against the word and revision that take effect now
        dif.word = new_word;
        dif.rev = st_next.ctrl.rev;
        dif.mod_en = st_next.ctrl.mod_en;
        dif.fec_en = st_next.ctrl.fec_en;
        st_next.set = dif.set;
        st_next.update = apply || wr_ctrl;
        if (apply) begin
            st_next.apply_cnt = st_reg.apply_cnt + 8'h01;
        end

        // Sticky reserved-bit flag: clear by writing one, a new hit wins
        if (wr_stat && HWDATA[`STAT_RSVD]) begin
            st_next.rsvd_seen = 1'b0;
        end
        if (apply && dif.rsvd_hit) begin
            st_next.rsvd_seen = 1'b1;
        end

        // Address phase
        st_next.wr_pend = bus_take && HWRITE;
        st_next.wr_ofs = HADDR[7:0];
        st_next.wr_hit = addr_hit;
        if (bus_take && !HWRITE) begin
            st_next.rdata = addr_hit ? read_view(HADDR[7:0], st_next) : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_reg <= reset_state();
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign HREADYOUT = CE;
    assign HRESP = 1'b0;
    assign HRDATA = st_reg.rdata;
    assign REV = st_reg.ctrl.rev;
    assign MOD_NRZ = st_reg.set.mod_nrz;
    assign MOD_PAM4 = st_reg.set.mod_pam4;
    assign MOD_DEFAULT = st_reg.set.mod_default;
    assign FEC_BASER = st_reg.set.fec_baser;
    assign FEC_RS = st_reg.set.fec_rs;
    assign FEC_NONE = st_reg.set.fec_none;
    assign EEE_EN = st_reg.set.eee;
    assign LT_EN = st_reg.set.lt;
    assign PD_EN = st_reg.set.pd;
    assign SETTINGS_UPDATE = st_reg.update;

endmodule : link_settings_field_decoder

// file: test/lsd_properties.sv
`timescale 1ns/1ps
module lsd_properties import lsd_pkg::*; (
    input wire logic MCLK, // Clock
    input wire logic RST, // Reset
    input wire logic CE, // Enable
    input wire logic CMD_VALID, // Word strobe
    input wire logic [31:0] CMD_WORD, // Word
    input wire lsd_pkg::rev_t REV, // Revision
    input wire logic MOD_NRZ, // NRZ
    input wire logic MOD_PAM4, // PAM-4
    input wire logic FEC_BASER, // BASE-R
    input wire logic FEC_RS, // RS
    input wire logic FEC_NONE, // No FEC
    input wire logic EEE_EN, // EEE
    input wire logic LT_EN, // Training
    input wire logic PD_EN, // Detect
    input wire logic SETTINGS_UPDATE // Pulse
);
    // ------------------------------------------------------------
    // Decode relations one cycle after a taken word; revision gate on selections every cycle
    // ------------------------------------------------------------
    logic take;
    assign take = CMD_VALID && CE;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    AST_MOD: assert property (take |=> !(MOD_NRZ || MOD_PAM4) ||
        {MOD_PAM4, MOD_NRZ} == $past(CMD_WORD[23:22])) else $error("bad modulation");
    AST_BASER: assert property (take && !CMD_WORD[24] |=> !FEC_BASER)
        else $error("bad BASE-R");
    AST_RS: assert property (take && !CMD_WORD[25] |=> !FEC_RS)
        else $error("bad RS");
    AST_NONE: assert property (take && CMD_WORD[25:24] == 2'h0 |=> FEC_NONE)
        else $error("bad no-FEC");
    AST_EEE: assert property (take |=> SETTINGS_UPDATE && EEE_EN == $past(CMD_WORD[28]))
        else $error("bad EEE");
    AST_LT: assert property (take |=> LT_EN == $past(CMD_WORD[29]))
        else $error("bad training");
    AST_PD: assert property (take |=> PD_EN == $past(CMD_WORD[30]))
        else $error("bad detect");
    AST_REV: assert property ((MOD_NRZ || MOD_PAM4 || FEC_BASER || FEC_RS) |-> REV == REV_1_2)
        else $error("selection at old revision");
endmodule : lsd_properties

bind link_settings_field_decoder lsd_properties chk_u (.MCLK(MCLK), .RST(RST), .CE(CE),
    .CMD_VALID(CMD_VALID), .CMD_WORD(CMD_WORD), .REV(REV), .MOD_NRZ(MOD_NRZ),
    .MOD_PAM4(MOD_PAM4), .FEC_BASER(FEC_BASER), .FEC_RS(FEC_RS), .FEC_NONE(FEC_NONE),
    .EEE_EN(EEE_EN), .LT_EN(LT_EN), .PD_EN(PD_EN), .SETTINGS_UPDATE(SETTINGS_UPDATE));

// file: test/cmd_source.sv
`timescale 1ns/1ps
module cmd_source (
    input wire logic clk, // Controller clock
    output logic valid, // Word strobe
    output logic [31:0] word // Link-settings word
);
    // ------------------------------------------------------------
    // One-cycle word strobe; word inverted when idle
    // ------------------------------------------------------------
    initial begin
        valid = 1'h0;
        word = 32'h0;
    end
    task automatic send(input logic [31:0] w, input logic raw);
        valid <= 1'h1;
        word <= raw ? w : (w & 32'hf3ff_ffff);
        @(posedge clk);
        valid <= 1'h0;
        word <= ~w;
    endtask : send
endmodule : cmd_source

// file: test/link_settings_field_decoder_test.sv
`timescale 1ns/1ps
module link_settings_field_decoder_test;
    import lsd_pkg::*;
    logic MCLK = 1'h0;
    logic RST = 1'h1;
    logic CE = 1'h1;
    logic HRESP;
    logic HSEL = 1'h0;
    logic HWRITE = 1'h0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA, CMD_WORD, q;
    logic HREADYOUT, CMD_VALID, MOD_NRZ, MOD_PAM4, MOD_DEFAULT, FEC_BASER, FEC_RS, FEC_NONE;
    logic EEE_EN, LT_EN, PD_EN, SETTINGS_UPDATE;
    rev_t REV;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] row_w [10] = '{32'h0, 32'h0040_ffff, 32'h0080_0000, 32'h00c0_0000,
        32'h0100_0000, 32'h0200_0000, 32'h0300_0000, 32'h1000_0000, 32'h2000_0000, 32'h7fc0_0000};
    logic [8:0] row_s [10] = '{9'h024, 9'h021, 9'h022, 9'h023, 9'h00c, 9'h014, 9'h01c,
        9'h064, 9'h0a4, 9'h1db};
    wire logic [8:0] sett = {PD_EN, LT_EN, EEE_EN, FEC_NONE, FEC_RS, FEC_BASER, MOD_DEFAULT,
        MOD_PAM4, MOD_NRZ};
    always #10 MCLK = ~MCLK;
    link_settings_field_decoder dut_u (.MCLK(MCLK), .RST(RST), .CE(CE), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
        .CMD_VALID(CMD_VALID), .CMD_WORD(CMD_WORD), .REV(REV), .MOD_NRZ(MOD_NRZ),
        .MOD_PAM4(MOD_PAM4), .MOD_DEFAULT(MOD_DEFAULT), .FEC_BASER(FEC_BASER), .FEC_RS(FEC_RS),
        .FEC_NONE(FEC_NONE), .EEE_EN(EEE_EN), .LT_EN(LT_EN), .PD_EN(PD_EN),
        .SETTINGS_UPDATE(SETTINGS_UPDATE));
    cmd_source src_u (.clk(MCLK), .valid(CMD_VALID), .word(CMD_WORD));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic wait_ready();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge MCLK);
            if (HREADYOUT === 1'h1) break;
        end
        if (i == 50) begin
            fails++;
            results();
        end
    endtask : wait_ready
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        HSEL <= 1'h1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= a;
        wait_ready();
        HSEL <= 1'h0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_ready();
        q = HRDATA;
    endtask : ahb
    initial begin
        repeat (8) @(posedge MCLK);
        RST <= 1'h0;
        @(posedge MCLK);
        #1;
        check({REV, sett}, {REV_1_2, 9'h024});
        @(posedge MCLK);
        for (int k = 0; k < 10; k++) begin
            src_u.send(row_w[k], 1'h0);
            #1;
            check({SETTINGS_UPDATE, sett}, {1'h1, row_s[k]});
            @(posedge MCLK);
        end
        src_u.send(32'h0c00_0000, 1'h1);
        #1;
        check(sett, 9'h024);
        @(posedge MCLK);
        ahb(1'h0, 32'h8, 32'h0);
        check(q & 32'h00ff_1fff, 32'h000b_1024);
        for (int r = 0; r < 2; r++) begin
            ahb(1'h1, 32'h0, 32'h30 | r);
            src_u.send(32'h73c0_0000, 1'h0);
            #1;
            check({REV, sett}, {r[1:0], 9'h1e4});
            @(posedge MCLK);
        end
        ahb(1'h1, 32'h0, 32'h32);
        @(posedge MCLK);
        #1;
        check({REV, sett}, {REV_1_2, 9'h1db});
        @(posedge MCLK);
        ahb(1'h1, 32'h4, 32'h0080_0000);
        @(posedge MCLK);
        #1;
        check(sett, 9'h022);
        @(posedge MCLK);
        ahb(1'h0, 32'h4, 32'h0);
        check(q, 32'h0080_0000);
        ahb(1'h0, 32'h0c, 32'h0);
        check(q, 32'h0);
        CE <= 1'h0;
        src_u.send(32'h1000_0000, 1'h0);
        #1;
        check({HRESP, HREADYOUT, SETTINGS_UPDATE, sett}, {3'h0, 9'h022});
        @(posedge MCLK);
        CE <= 1'h1;
        results();
    end
endmodule : link_settings_field_decoder_test
